// >>> src/adcsr_pkg.sv
// Constants for the status word and calibration coefficient register access block.
package adcsr_pkg;

	// ----------------------------------------------------------------
	// Port select codes
	// ----------------------------------------------------------------
	localparam logic PORT_SEL_CONTROL = 1'h0;
	localparam logic PORT_SEL_CAL = 1'h1;

	// ----------------------------------------------------------------
	// Control word field positions
	// ----------------------------------------------------------------
	localparam int CTL_SINGLE_OR_DIFFERENTIAL_BIT = 13;
	localparam int CTL_CHAN_HI = 12;
	localparam int CTL_CHAN_LO = 10;
	localparam int CTL_POWER_HI = 9;
	localparam int CTL_POWER_LO = 8;
	localparam int CTL_READ_SEL_HI = 7;
	localparam int CTL_READ_SEL_LO = 6;
	localparam int CTL_ANALOG_RANGE_MODE_BIT = 5;
	localparam int CTL_CAL_KIND_BIT = 3;
	localparam int CTL_CAL_SEL_HI = 2;
	localparam int CTL_CAL_SEL_LO = 1;
	localparam int CTL_START_CAL_BIT = 0;

	// ----------------------------------------------------------------
	// Read select codes
	// ----------------------------------------------------------------
	localparam logic [1:0] READ_SEL_RESULT = 2'h0;
	localparam logic [1:0] READ_SEL_CAL = 2'h2;
	localparam logic [1:0] READ_SEL_STATUS = 2'h3;

	// ----------------------------------------------------------------
	// Calibration selection codes and pointer indices
	// ----------------------------------------------------------------
	localparam logic [1:0] CAL_SEL_ALL = 2'h0;
	localparam logic [1:0] CAL_SEL_GAIN_OFFSET = 2'h1;
	localparam logic [1:0] CAL_SEL_OFFSET = 2'h2;
	localparam logic [1:0] CAL_SEL_GAIN = 2'h3;
	localparam int CAL_COUNT = 10;
	localparam int CAL_DATA_W = 14;
	localparam logic [3:0] CAL_IDX_GAIN = 4'h0;
	localparam logic [3:0] CAL_IDX_OFFSET = 4'h1;
	localparam logic [3:0] CAL_IDX_DAC_LAST = 4'h9;

	// ----------------------------------------------------------------
	// Reset values
	// ----------------------------------------------------------------
	localparam logic [13:0] OFFSET_RESET = 14'h2000;
	localparam logic [13:0] GAIN_RESET = 14'h2000;
	localparam logic [13:0] DAC_RESET = 14'h0000;
	localparam logic [15:0] CONTROL_RESET = 16'h0000;

	// ----------------------------------------------------------------
	// Fixed status and calibration read bit values
	// ----------------------------------------------------------------
	localparam logic [1:0] STATUS_TOP_FIXED = 2'h0;
	localparam logic [1:0] STATUS_MID_FIXED = 2'h3;
	localparam logic [1:0] CAL_READ_LEAD = 2'h0;

endpackage

// >>> src/adcsr_sync.sv
// Two flip-flop synchroniser for a group of pin levels.
`timescale 1ns/10ps
module adcsr_sync #(
	parameter int WIDTH = 1,
	parameter logic [WIDTH-1:0] RESET_VALUE = '0
) (
	input wire logic sys_clk,
	input wire logic reset_n,
	input wire logic [WIDTH-1:0] async_in,
	output logic [WIDTH-1:0] sync_out
);

	logic [WIDTH-1:0] first_stage;

	// The first stage feeds only the second stage, so metastability settles there.
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			first_stage <= RESET_VALUE;
			sync_out <= RESET_VALUE;
		end else begin
			first_stage <= async_in;
			sync_out <= first_stage;
		end
	end

endmodule

// >>> src/adcsr_top.sv
// Status word and calibration coefficient register access behind the parallel port.
`timescale 1ns/10ps

// What this block does
// RULE1: Status bits 15,14 zero; 7,6 one.
// RULE2: Status 13..10 show input and channel.
// RULE3: Status 9,8 show power setting bits.
// RULE4: Status bit 5 shows analog mode.
// RULE5: Status bit 4 shows conversion or calibration busy.
// RULE6: Status bit 3 shows calibration kind.
// RULE7: Status bits 2,1 echo calibration select.
// RULE8: Status bit 0 shows calibration running.
// RULE9: Ten host readable and writable calibration registers.
// RULE10: Calibration engine updates registers automatically.
// RULE11: Select field picks all, pair, offset, gain.
// RULE12: Host never mixes reads and writes.
// RULE13: Host selects calibration reads before reading.
// RULE14: Pointer restarts on control write or end.
// RULE15: Pointer starts at gain, offset-only excepted.
// RULE16: Pointer advances after each full access.
// RULE17: Byte mode advances after high byte.
// RULE18: Host accesses low byte first.
// RULE19: Abandoned sequence restarts on next control write.
// RULE20: Calibration reads carry two leading zeros.
// RULE21: Offset register has 14 data bits.
// RULE22: Offset register defaults near 2000 hex.
// RULE23: Read select 11 picks the status word.
// RULE24: Status fields power up as zero.
// RULE25: Gain register has 14 data bits.
// RULE26: Full order: gain, offset, eight DAC.
module adcsr_top
	import adcsr_pkg::*;
(
	input wire logic sys_clk,
	input wire logic reset_n,
	input wire logic chip_select_n,
	input wire logic read_n,
	input wire logic write_n,
	input wire logic port_select,
	input wire logic high_byte_enable,
	input wire logic byte_mode,
	input wire logic [15:0] data_in,
	output logic [15:0] data_out,
	output logic data_oe_n,
	input wire logic conversion_busy,
	input wire logic calibration_busy,
	input wire logic [11:0] conversion_result,
	input wire logic engine_write,
	input wire logic [3:0] engine_index,
	input wire logic [13:0] engine_data,
	output logic start_calibration,
	output logic single_or_differential,
	output logic [2:0] channel_select,
	output logic [1:0] power_setting,
	output logic analog_range_mode,
	output logic calibration_kind,
	output logic [1:0] calibration_select,
	output logic [13:0] gain_coefficient,
	output logic [13:0] offset_trim_coefficient,
	output logic [8*14-1:0] dac_coefficients
);

	// ----------------------------------------------------------------
	// Reset release
	// ----------------------------------------------------------------
	logic [1:0] reset_pipe;
	logic rst_n;

	// Asynchronous assertion, release lined up with the clock.
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			reset_pipe <= 2'h0;
		end else begin
			reset_pipe <= {reset_pipe[0], 1'h1};
		end
	end
	assign rst_n = reset_pipe[1];

	// ----------------------------------------------------------------
	// Pin synchronisers
	// ----------------------------------------------------------------
	logic [5:0] strobe_sync;
	logic [15:0] data_sync;
	logic [1:0] status_sync;
	logic cs_n_s;
	logic rd_n_s;
	logic wr_n_s;
	logic port_s;
	logic high_byte_enable_s;
	logic byte_s;

	adcsr_sync #(
		.WIDTH(6),
		.RESET_VALUE(6'h07)
	) strobe_sync_inst (
		.sys_clk(sys_clk),
		.reset_n(rst_n),
		.async_in({byte_mode, high_byte_enable, port_select, chip_select_n, read_n, write_n}),
		.sync_out(strobe_sync)
	);

	adcsr_sync #(
		.WIDTH(16),
		.RESET_VALUE(16'h0000)
	) data_sync_inst (
		.sys_clk(sys_clk),
		.reset_n(rst_n),
		.async_in(data_in),
		.sync_out(data_sync)
	);

	adcsr_sync #(
		.WIDTH(2),
		.RESET_VALUE(2'h0)
	) busy_sync_inst (
		.sys_clk(sys_clk),
		.reset_n(rst_n),
		.async_in({conversion_busy, calibration_busy}),
		.sync_out(status_sync)
	);

	assign wr_n_s = strobe_sync[0];
	assign rd_n_s = strobe_sync[1];
	assign cs_n_s = strobe_sync[2];
	assign port_s = strobe_sync[3];
	assign high_byte_enable_s = strobe_sync[4];
	assign byte_s = strobe_sync[5];

	// ----------------------------------------------------------------
	// Strobe edge detection
	// ----------------------------------------------------------------
	logic wr_n_prev;
	logic rd_n_prev;
	logic cs_n_prev;
	logic write_done;
	logic read_done;
	logic read_active;

	// Accesses complete on the trailing edge, as on any asynchronous parallel port.
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			wr_n_prev <= 1'h1;
			rd_n_prev <= 1'h1;
			cs_n_prev <= 1'h1;
		end else begin
			wr_n_prev <= wr_n_s;
			rd_n_prev <= rd_n_s;
			cs_n_prev <= cs_n_s;
		end
	end
	assign write_done = wr_n_s && !wr_n_prev && !cs_n_prev;
	assign read_done = rd_n_s && !rd_n_prev && !cs_n_prev;
	assign read_active = !rd_n_s && !cs_n_s;

	// ----------------------------------------------------------------
	// Control fields
	// ----------------------------------------------------------------
	logic [15:0] control;
	logic control_write;
	logic cal_write;
	logic [1:0] read_select;

	assign control_write = write_done && (port_s == PORT_SEL_CONTROL);
	assign cal_write = write_done && (port_s == PORT_SEL_CAL);

	// Control word captured whole; start bit is never kept, it only pulses.
	// RULE24: fields power up zero
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			control <= CONTROL_RESET;
		end else if (control_write) begin
			control <= data_sync & ~(16'h0001 << CTL_START_CAL_BIT);
		end
	end

	// One-cycle request to the calibration engine.
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			start_calibration <= 1'h0;
		end else begin
			start_calibration <= control_write && data_sync[CTL_START_CAL_BIT];
		end
	end

	assign single_or_differential = control[CTL_SINGLE_OR_DIFFERENTIAL_BIT];
	assign channel_select = control[CTL_CHAN_HI:CTL_CHAN_LO];
	assign power_setting = control[CTL_POWER_HI:CTL_POWER_LO];
	assign read_select = control[CTL_READ_SEL_HI:CTL_READ_SEL_LO];
	assign analog_range_mode = control[CTL_ANALOG_RANGE_MODE_BIT];
	assign calibration_kind = control[CTL_CAL_KIND_BIT];
	assign calibration_select = control[CTL_CAL_SEL_HI:CTL_CAL_SEL_LO];

	// ----------------------------------------------------------------
	// Calibration pointer
	// ----------------------------------------------------------------
	logic [3:0] pointer;
	logic [3:0] next_pointer;
	logic [3:0] first_index;
	logic [3:0] last_index;
	logic [1:0] next_sel;
	logic cal_read;
	logic full_access;

	// The restart point depends on the selection being written, not the old one.
	assign next_sel = control_write ? data_sync[CTL_CAL_SEL_HI:CTL_CAL_SEL_LO] : calibration_select;

	// RULE15: offset-only starts at offset
	always_comb begin
		first_index = CAL_IDX_GAIN;
		if (next_sel == CAL_SEL_OFFSET) begin
			first_index = CAL_IDX_OFFSET;
		end
	end

	// RULE11: selection decides the set
	// RULE26: gain, offset, then DACs
	always_comb begin
		case (calibration_select)
			CAL_SEL_ALL: begin
				last_index = CAL_IDX_DAC_LAST;
			end
			CAL_SEL_GAIN_OFFSET: begin
				last_index = CAL_IDX_OFFSET;
			end
			CAL_SEL_OFFSET: begin
				last_index = CAL_IDX_OFFSET;
			end
			CAL_SEL_GAIN: begin
				last_index = CAL_IDX_GAIN;
			end
			default: begin
				last_index = CAL_IDX_GAIN;
			end
		endcase
	end

	assign cal_read = read_done && (read_select == READ_SEL_CAL);
	// RULE17: byte mode completes on high byte
	assign full_access = (cal_write || cal_read) && (!byte_s || high_byte_enable_s);

	// RULE14: restart on control write
	// RULE19: abandoned sequence restarts here
	// RULE16: advance after full access
	always_comb begin
		next_pointer = pointer;
		if (control_write) begin
			next_pointer = first_index;
		end else if (full_access) begin
			if (pointer >= last_index) begin
				next_pointer = first_index;
			end else begin
				next_pointer = pointer + 4'h1;
			end
		end
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			pointer <= CAL_IDX_GAIN;
		end else begin
			pointer <= next_pointer;
		end
	end

	// ----------------------------------------------------------------
	// Calibration coefficient storage
	// ----------------------------------------------------------------
	logic [CAL_DATA_W-1:0] cal_regs [CAL_COUNT];
	logic [CAL_DATA_W-1:0] host_value;
	logic [CAL_DATA_W-1:0] current_value;

	assign current_value = cal_regs[pointer];

	// Byte writes merge into the coefficient; word writes replace it.
	// RULE21: offset holds 14 bits
	// RULE25: gain holds 14 bits
	always_comb begin
		host_value = data_sync[CAL_DATA_W-1:0];
		if (byte_s) begin
			if (high_byte_enable_s) begin
				host_value = {data_sync[5:0], current_value[7:0]};
			end else begin
				host_value = {current_value[13:8], data_sync[7:0]};
			end
		end
	end

	// The engine wins a collision: it only runs while the host is told to stay away.
	// RULE9: ten host accessible registers
	// RULE10: engine updates coefficients
	// RULE22: offset default value
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			for (int i = 0; i < CAL_COUNT; i++) begin
				cal_regs[i] <= DAC_RESET;
			end
			cal_regs[CAL_IDX_GAIN] <= GAIN_RESET;
			cal_regs[CAL_IDX_OFFSET] <= OFFSET_RESET;
		end else if (engine_write && (engine_index < 4'(CAL_COUNT))) begin
			cal_regs[engine_index] <= engine_data;
		end else if (cal_write) begin
			cal_regs[pointer] <= host_value;
		end
	end

	assign gain_coefficient = cal_regs[CAL_IDX_GAIN];
	assign offset_trim_coefficient = cal_regs[CAL_IDX_OFFSET];

	generate
		for (genvar g = 0; g < 8; g++) begin : g_dac
			assign dac_coefficients[g*14 +: 14] = cal_regs[g + 2];
		end
	endgenerate

	// ----------------------------------------------------------------
	// Status word
	// ----------------------------------------------------------------
	logic [15:0] device_state_word;
	logic any_busy;

	assign any_busy = status_sync[1] || status_sync[0];

	// Live fields: the word always reflects the settings now in force.
	// RULE1: fixed bits
	// RULE2: input and channel
	// RULE3: power bits
	// RULE4: analog mode
	// RULE5: busy bit
	// RULE6: calibration kind
	// RULE7: selection echo
	// RULE8: calibration running
	assign device_state_word = {STATUS_TOP_FIXED, single_or_differential, channel_select,
		power_setting, STATUS_MID_FIXED, analog_range_mode, any_busy,
		calibration_kind, calibration_select, status_sync[0]};

	// ----------------------------------------------------------------
	// Read data path
	// ----------------------------------------------------------------
	logic [15:0] read_word;
	logic [15:0] next_data;
	logic [15:0] cal_word;

	// RULE20: two leading zeros
	assign cal_word = {CAL_READ_LEAD, current_value};

	// RULE23: status word on select 11
	always_comb begin
		case (read_select)
			READ_SEL_STATUS: begin
				read_word = device_state_word;
			end
			READ_SEL_CAL: begin
				read_word = cal_word;
			end
			default: begin
				read_word = {4'h0, conversion_result};
			end
		endcase
	end

	// In byte mode both halves leave on the low lane, chosen by the high byte enable.
	always_comb begin
		next_data = read_word;
		if (byte_s) begin
			next_data = {8'h00, high_byte_enable_s ? read_word[15:8] : read_word[7:0]};
		end
	end

	// Data is refreshed every cycle so a slow strobe sees settled values.
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			data_out <= 16'h0000;
			data_oe_n <= 1'h1;
		end else begin
			data_out <= next_data;
			data_oe_n <= !read_active;
		end
	end

endmodule

// >>> sim/adcsr_top_asserts.sv
// Port-level checks for the status and calibration access block.
`timescale 1ns/10ps
module adcsr_top_asserts (
	input wire logic sys_clk,
	input wire logic reset_n,
	input wire logic chip_select_n,
	input wire logic read_n,
	input wire logic write_n,
	input wire logic data_oe_n,
	input wire logic engine_write,
	input wire logic [3:0] engine_index,
	input wire logic [13:0] engine_data,
	input wire logic start_calibration,
	input wire logic [2:0] channel_select,
	input wire logic [1:0] calibration_select,
	input wire logic [13:0] gain_coefficient,
	input wire logic [13:0] offset_trim_coefficient
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!reset_n);
	a_oe_drive: assert property ((!chip_select_n && !read_n)[*5] |-> !data_oe_n)
		else $error("read data not driven");
	a_oe_release: assert property (read_n[*5] |-> data_oe_n)
		else $error("data bus driven while idle");
	a_start_pulse: assert property (start_calibration |=> !start_calibration)
		else $error("start pulse too long");
	a_start_quiet: assert property (write_n[*8] |-> !start_calibration)
		else $error("start pulse without a write");
	a_ctl_hold: assert property (write_n[*8] |-> $stable(calibration_select) && $stable(channel_select))
		else $error("control field moved without a write");
	a_gain_engine: assert property (engine_write && engine_index == 4'h0 |=> gain_coefficient == $past(engine_data))
		else $error("engine gain update lost");
	a_offset_engine: assert property (engine_write && engine_index == 4'h1
		|=> offset_trim_coefficient == $past(engine_data))
		else $error("engine offset update lost");
	a_coef_hold: assert property ((write_n && !engine_write)[*8]
		|-> $stable(offset_trim_coefficient) && $stable(gain_coefficient))
		else $error("coefficient moved without a write");
endmodule
bind adcsr_top adcsr_top_asserts adcsr_top_asserts_i (.sys_clk(sys_clk), .reset_n(reset_n),
	.chip_select_n(chip_select_n), .read_n(read_n), .write_n(write_n), .data_oe_n(data_oe_n),
	.engine_write(engine_write), .engine_index(engine_index), .engine_data(engine_data),
	.start_calibration(start_calibration), .channel_select(channel_select),
	.calibration_select(calibration_select), .gain_coefficient(gain_coefficient),
	.offset_trim_coefficient(offset_trim_coefficient));

// >>> sim/adcsr_host.sv
// Behavioural host processor on the parallel port.
`timescale 1ns/10ps
module adcsr_host (
	input wire logic sys_clk,
	input wire logic [15:0] data_out,
	input wire logic data_oe_n,
	output logic chip_select_n,
	output logic read_n,
	output logic write_n,
	output logic port_select,
	output logic high_byte_enable,
	output logic byte_mode,
	output logic [15:0] data_in
);
	initial begin
		{chip_select_n, read_n, write_n} = 3'h7;
		{port_select, high_byte_enable, byte_mode} = 3'h0;
		data_in = 16'h0000;
	end
	task step(input int n);
		repeat (n) @(posedge sys_clk);
		#2;
	endtask
	// Strobes are held long enough for the two-stage pin synchronisers.
	task wr(input logic ps, input logic hb, input logic [15:0] d);
		step(1);
		{port_select, high_byte_enable, data_in} = {ps, hb, d};
		{chip_select_n, write_n} = 2'h0;
		step(4);
		write_n = 1;
		step(4);
		chip_select_n = 1;
		// Released bus shows the inverse so a stale value cannot pass.
		data_in = ~d;
		// Three idle edges here keep four clocks between strobe edges across calls.
		step(3);
	endtask
	task rd(input logic hb, output logic [15:0] d, output logic oe);
		step(1);
		high_byte_enable = hb;
		{chip_select_n, read_n} = 2'h0;
		step(5);
		d = data_out;
		oe = data_oe_n;
		read_n = 1;
		step(4);
		chip_select_n = 1;
		step(3);
	endtask
endmodule

// >>> sim/adcsr_top_tb.sv
// Self-checking bench for the status and calibration access block.
`timescale 1ns/10ps
module adcsr_top_tb;
	import adcsr_pkg::*;
	typedef struct {logic cb; logic kb; logic [15:0] ctl; logic [15:0] st;} adcsr_row_t;
	adcsr_row_t rows [4] = '{'{0, 0, 16'h00C0, 16'h00C0}, '{1, 0, 16'h3FC0, 16'h3FD0},
		'{0, 1, 16'hE5EE, 16'h25FF}, '{1, 1, 16'h00C6, 16'h00D7}};
	logic sys_clk = 0, reset_n = 0, conversion_busy = 0, calibration_busy = 0, engine_write = 0;
	logic [3:0] engine_index = 4'h0;
	logic [13:0] engine_data = 14'h0000;
	logic [11:0] conversion_result = 12'hA5C;
	logic chip_select_n, read_n, write_n, port_select, high_byte_enable, byte_mode, data_oe_n, oe;
	logic start_calibration;
	logic pin_sgl, pin_analog_range_mode, pin_kind;
	logic [2:0] pin_chan;
	logic [1:0] pin_power, pin_csel;
	logic [13:0] pin_gain, pin_offset;
	logic [111:0] pin_dac;
	logic [15:0] pin_fields;
	// Control outputs laid out as in the control word, so a row's write can be compared directly.
	assign pin_fields = {2'h0, pin_sgl, pin_chan, pin_power, 2'h0, pin_analog_range_mode, 1'b0, pin_kind, pin_csel, 1'b0};
	logic [15:0] data_in, data_out, d;
	logic [13:0] mem [10];
	int n_mismatch = 0, checks = 0, starts = 0;
	always #12.5 sys_clk = ~sys_clk;
	always @(posedge sys_clk) if (start_calibration === 1'b1) starts++;
	adcsr_host adcsr_host_i (.sys_clk(sys_clk), .data_out(data_out), .data_oe_n(data_oe_n),
		.chip_select_n(chip_select_n), .read_n(read_n), .write_n(write_n), .port_select(port_select),
		.high_byte_enable(high_byte_enable), .byte_mode(byte_mode), .data_in(data_in));
	adcsr_top adcsr_top_i (.sys_clk(sys_clk), .reset_n(reset_n), .chip_select_n(chip_select_n),
		.read_n(read_n), .write_n(write_n), .port_select(port_select), .high_byte_enable(high_byte_enable),
		.byte_mode(byte_mode), .data_in(data_in), .data_out(data_out), .data_oe_n(data_oe_n),
		.conversion_busy(conversion_busy), .calibration_busy(calibration_busy),
		.conversion_result(conversion_result), .engine_write(engine_write), .engine_index(engine_index),
		.engine_data(engine_data), .start_calibration(start_calibration), .single_or_differential(pin_sgl),
		.channel_select(pin_chan), .power_setting(pin_power), .analog_range_mode(pin_analog_range_mode),
		.calibration_kind(pin_kind), .calibration_select(pin_csel), .gain_coefficient(pin_gain),
		.offset_trim_coefficient(pin_offset), .dac_coefficients(pin_dac));
	task chk(input string n, input logic [15:0] e, input logic [15:0] s);
		checks++;
		if (s !== e) begin
			n_mismatch++;
			$display("[ERR] %s expected %h seen %h", n, e, s);
		end
	endtask
	task close_out;
		$display("checks %0d mismatches %0d", checks, n_mismatch);
		if (n_mismatch == 0 && checks > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask
	task ctl(input logic [15:0] w);
		adcsr_host_i.wr(PORT_SEL_CONTROL, 1'b0, w);
	endtask
	task rk(input int i);
		adcsr_host_i.rd(1'b0, d, oe);
		chk("coefficient", {2'h0, mem[i]}, d);
	endtask
	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		mem = '{GAIN_RESET, OFFSET_RESET, DAC_RESET, DAC_RESET, DAC_RESET, DAC_RESET, DAC_RESET,
			DAC_RESET, DAC_RESET, DAC_RESET};
		repeat (2) @(posedge sys_clk);
		#2 reset_n = 1;
		repeat (8) @(posedge sys_clk);
		// Status rows, busy inputs beside the control word.
		for (int r = 0; r < 4; r++) begin
			{conversion_busy, calibration_busy} = {rows[r].cb, rows[r].kb};
			ctl(rows[r].ctl);
			adcsr_host_i.rd(1'b0, d, oe);
			chk("status", rows[r].st, d);
			chk("fields", rows[r].ctl & 16'h3F2E, pin_fields);
			chk("oe", 16'h0000, {15'h0, oe});
		end
		{conversion_busy, calibration_busy} = 2'h0;
		// Power-up contents walked in full order, then the wrap.
		// read select set first.
		ctl(16'h0080);
		for (int i = 0; i < 11; i++) rk(i % 10);
		ctl(16'h0000);
		adcsr_host_i.rd(1'b0, d, oe);
		chk("result", {4'h0, conversion_result}, d);
		// writes and reads never share a sequence.
		// Top bits written as ones must read back as zero.
		for (int i = 0; i < 10; i++) begin
			mem[i] = 14'(16'h1111 * i + 16'h0357);
			adcsr_host_i.wr(PORT_SEL_CAL, 1'b0, {2'h3, mem[i]});
		end
		chk("gain pin", {2'h0, mem[0]}, {2'h0, pin_gain});
		chk("offset pin", {2'h0, mem[1]}, {2'h0, pin_offset});
		for (int k = 2; k < 10; k++) chk("dac pin", {2'h0, mem[k]}, {2'h0, pin_dac[(k - 2) * 14 +: 14]});
		ctl(16'h0080);
		for (int i = 0; i < 10; i++) rk(i);
		for (int s = 1; s < 4; s++) begin
			ctl(16'h0080 | 16'(s << 1));
			for (int k = 0; k < 3; k++) rk(s == 1 ? k % 2 : int'(s == 2));
		end
		// Abandoned sequence restarts at gain.
		ctl(16'h0080);
		rk(0);
		rk(1);
		ctl(16'h0080);
		rk(0);
		// Byte transfers, low byte then high byte.
		// low byte goes first.
		ctl(16'h0002);
		adcsr_host_i.byte_mode = 1;
		foreach (rows[j]) adcsr_host_i.wr(PORT_SEL_CAL, j[0], {8'h00, 8'(32'h12FF5634 >> (j * 8))});
		adcsr_host_i.byte_mode = 0;
		ctl(16'h0082);
		adcsr_host_i.byte_mode = 1;
		foreach (rows[j]) begin
			adcsr_host_i.rd(j[0], d, oe);
			// A high byte keeps six data bits, so 56 hex comes back as 16 hex.
			chk("byte", {8'h00, 8'(32'h12FF1634 >> (j * 8))}, {8'h00, d[7:0]});
		end
		adcsr_host_i.byte_mode = 0;
		// Engine updates offset, gain and the last DAC on three edges in a row, then start pulse.
		@(posedge sys_clk);
		#2 {engine_write, engine_index, engine_data} = {1'b1, 4'h1, 14'h0ABC};
		@(posedge sys_clk);
		#2 {engine_index, engine_data} = {4'h0, 14'h1DEF};
		@(posedge sys_clk);
		#2 {engine_index, engine_data} = {4'h9, 14'h0123};
		@(posedge sys_clk);
		#2 engine_write = 0;
		mem[0] = 14'h1DEF;
		mem[1] = 14'h0ABC;
		mem[9] = 14'h0123;
		chk("engine gain", {2'h0, mem[0]}, {2'h0, pin_gain});
		chk("engine offset", {2'h0, mem[1]}, {2'h0, pin_offset});
		chk("engine dac", {2'h0, mem[9]}, {2'h0, pin_dac[7 * 14 +: 14]});
		ctl(16'h0084);
		rk(1);
		ctl(16'h0001);
		chk("starts", 16'h0001, 16'(starts));
		// Reset in mid-run must bring back the power-up contents.
		@(posedge sys_clk);
		#2 reset_n = 0;
		@(posedge sys_clk);
		#2 chk("reset gain", {2'h0, GAIN_RESET}, {2'h0, pin_gain});
		chk("reset offset", {2'h0, OFFSET_RESET}, {2'h0, pin_offset});
		chk("reset fields", 16'h0000, pin_fields);
		chk("reset oe", 16'h0001, {15'h0, data_oe_n});
		@(posedge sys_clk);
		#2 reset_n = 1;
		repeat (8) @(posedge sys_clk);
		mem[0] = GAIN_RESET;
		ctl(16'h0080);
		rk(0);
		ctl(16'h00C0);
		adcsr_host_i.rd(1'b0, d, oe);
		chk("reset status", 16'h00C0, d);
		close_out();
	end
endmodule
